/* File: rtl/gain_rom.sv */
/*
 * Two-port gain mantissa table, one entry per eighth-dB within a halving.
 * Read data are registered; the table is built from constants at elaboration.
 */
module gain_rom
    import volume_mix_pkg::*;
#(
    parameter int DEPTH = SEG_STEPS,
    parameter int WIDTH = MANT_W
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    input  wire logic [$clog2(DEPTH)-1:0] addr_a,
    input  wire logic [$clog2(DEPTH)-1:0] addr_b,
    output logic      [WIDTH-1:0]         data_a_q,
    output logic      [WIDTH-1:0]         data_b_q
);

    // Repeated multiply by one eighth-dB; drift stays below 0.03 dB per halving
    function automatic logic [31:0] mant_entry(input int idx);
        logic [31:0] m;
        m = MANT_UNITY;
        for (int k = 0; k < idx; k++) begin
            m = 32'((64'(m) * 64'(MANT_STEP)) >> 16);
        end
        return m;
    endfunction : mant_entry

    logic [WIDTH-1:0] table_c [DEPTH];
    logic [WIDTH-1:0] data_a_d;
    logic [WIDTH-1:0] data_b_d;

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            table_c[i] = WIDTH'(mant_entry(i));
        end
        data_a_d = table_c[addr_a];
        data_b_d = table_c[addr_b];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            data_a_q <= '0;
            data_b_q <= '0;
        end else begin
            data_a_q <= data_a_d;
            data_b_q <= data_b_d;
        end
    end

endmodule : gain_rom

/* File: rtl/volume_mix_ctrl.sv */
/*
 * Volume, mute, mixing and mode control: control-port registers with freeze,
 * per-channel level engines (immediate, soft ramp, zero cross), mixing matrix.
 * Assumes one sample_valid pulse per left/right clock period, samples signed.
 */
module volume_mix_ctrl
    import volume_mix_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [2:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                two_wire_mode,
    output logic      [7:0]          reg_rdata,
    output logic                     reg_rvalid,
    input  wire logic                sample_valid,
    input  wire logic [SAMPLE_W-1:0] sample_left,
    input  wire logic [SAMPLE_W-1:0] sample_right,
    output logic      [SAMPLE_W-1:0] analog_out_left_chan,
    output logic      [SAMPLE_W-1:0] analog_out_right_chan,
    output logic                     out_valid,
    output logic                     silence_indicator_left,
    output logic                     silence_indicator_right,
    output logic                     low_power_state,
    output logic                     master_clock_halve,
    output logic                     rolloff_select,
    output logic                     host_port_enable
);

    typedef logic signed [SAMPLE_W-1:0] smp_t;

    function automatic smp_t avg2(input smp_t x, input smp_t y);
        logic signed [SAMPLE_W:0] s;
        // Sign-extended sum in one extra bit, so the average cannot overflow
        s = {x[SAMPLE_W-1], x} + {y[SAMPLE_W-1], y};
        return smp_t'(s >>> 1);
    endfunction : avg2

    function automatic smp_t pick(input logic [1:0] sel, input smp_t l, input smp_t r);
        unique case (sel)
            2'b00: return '0;
            2'b01: return r;
            2'b10: return l;
            2'b11: return avg2(l, r);
        endcase
    endfunction : pick

    function automatic smp_t atten(input smp_t s, input logic [MANT_W-1:0] m, input logic [4:0] seg,
                                   input logic mute);
        logic signed [SAMPLE_W+MANT_W:0] p;
        p = s * $signed({1'b0, m});
        p = p >>> (MANT_FRAC + int'(seg));
        return mute ? '0 : smp_t'(p);
    endfunction : atten

    function automatic smp_t negate_sat(input smp_t s);
        return (s == {1'b1, {(SAMPLE_W-1){1'b0}}}) ? {1'b0, {(SAMPLE_W-1){1'b1}}} : -s;
    endfunction : negate_sat

    // Register file: shadow holds writes, applied drives the datapath
    ctl_regs_s shadow_q, shadow_d, applied_q, applied_d, eff;
    logic [7:0] rdata_d;
    logic       rvalid_d;

    always_comb begin
        shadow_d = shadow_q;
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_MIX:   shadow_d.mix   = reg_wdata;
                ADDR_VOL_A: shadow_d.vol_a = reg_wdata;
                ADDR_VOL_B: shadow_d.vol_b = reg_wdata;
                ADDR_MODE2: shadow_d.mode2 = reg_wdata & MASK_MODE2;
                ADDR_MODE3: shadow_d.mode3 = reg_wdata & MASK_MODE3;
                default:    shadow_d = shadow_q;
            endcase
        end
        // Applied set only follows while freeze is clear, so frozen edits land together
        applied_d = shadow_q.mode2[M2_FREEZE_BIT] ? applied_q : shadow_q;
        rvalid_d = reg_rd && two_wire_mode;
        unique case (reg_addr)
            ADDR_MIX:   rdata_d = shadow_q.mix;
            ADDR_VOL_A: rdata_d = shadow_q.vol_a;
            ADDR_VOL_B: rdata_d = shadow_q.vol_b;
            ADDR_MODE2: rdata_d = shadow_q.mode2;
            ADDR_MODE3: rdata_d = shadow_q.mode3;
            default:    rdata_d = 8'h00;
        endcase
        if (!rvalid_d) begin
            rdata_d = 8'h00;
        end
        // Stand-alone defaults rule while the control port is off
        eff = applied_q.mode2[M2_HOST_PORT_ENABLE_BIT] ? applied_q : CTL_STANDALONE;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            shadow_q   <= CTL_RESET;
            applied_q  <= CTL_RESET;
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            shadow_q   <= shadow_d;
            applied_q  <= applied_d;
            reg_rdata  <= rdata_d;
            reg_rvalid <= rvalid_d;
        end
    end

    // Level engines, one per channel: index 0 is A (left), 1 is B (right)
    logic [LEVEL_W-1:0] cur_q [2], cur_d [2], tgt [2];
    logic [TIMER_W-1:0] timer_q [2], timer_d [2];
    smp_t               prev_q [2], prev_d [2], in_s [2];
    change_mode_e       mode [2];
    logic [7:0]         vol_byte [2];
    logic               zc [2], tmo [2], step_ok [2], muted [2];
    logic               low_power_request, pdn_prev_q, wake_q, wake_d;

    always_comb begin
        low_power_request = eff.mode2[M2_PDN_BIT];
        in_s[0] = smp_t'(sample_left);
        in_s[1] = smp_t'(sample_right);
        for (int ch = 0; ch < 2; ch++) begin
            vol_byte[ch] = (ch == 1 && !eff.mix[MIX_LINK_BIT]) ? eff.vol_b : eff.vol_a;
            tgt[ch] = (low_power_request || vol_byte[ch][VOL_MUTE_BIT]) ? MUTE_LEVEL
                    : LEVEL_W'({vol_byte[ch][6:0], 3'b000});
            mode[ch] = change_mode_e'(eff.mix[MIX_MODE_LSB +: 2]);
            if (low_power_request && !eff.mode3[M3_RDN_BIT]) begin
                mode[ch] = LC_IMMEDIATE;
            end
            if (wake_q && !eff.mode3[M3_RUP_BIT]) begin
                mode[ch] = LC_IMMEDIATE;
            end
            // Exact zero counts as a crossing; each channel watches only its own input
            zc[ch] = sample_valid && ((in_s[ch] == '0) || (in_s[ch][SAMPLE_W-1] != prev_q[ch][SAMPLE_W-1]));
            tmo[ch] = sample_valid && (timer_q[ch] == ZC_TIMEOUT_LAST);
            unique case (mode[ch])
                LC_IMMEDIATE:  step_ok[ch] = 1'b1;
                LC_ZERO_CROSS: step_ok[ch] = zc[ch] || tmo[ch];
                LC_SOFT:       step_ok[ch] = sample_valid;
                LC_SOFT_ZERO:  step_ok[ch] = zc[ch] || tmo[ch];
            endcase
            cur_d[ch] = cur_q[ch];
            timer_d[ch] = timer_q[ch];
            if (cur_q[ch] == tgt[ch]) begin
                timer_d[ch] = '0;
            end else if (step_ok[ch]) begin
                timer_d[ch] = '0;
                if (mode[ch] == LC_SOFT || mode[ch] == LC_SOFT_ZERO) begin
                    cur_d[ch] = (cur_q[ch] < tgt[ch]) ? cur_q[ch] + 1'b1 : cur_q[ch] - 1'b1;
                end else begin
                    cur_d[ch] = tgt[ch];
                end
            end else if (sample_valid) begin
                timer_d[ch] = timer_q[ch] + 1'b1;
            end
            prev_d[ch] = sample_valid ? in_s[ch] : prev_q[ch];
            muted[ch] = vol_byte[ch][VOL_MUTE_BIT] && (cur_q[ch] == MUTE_LEVEL);
        end
        // Wake phase covers the climb out of power-down
        wake_d = wake_q;
        if (pdn_prev_q && !low_power_request) begin
            wake_d = 1'b1;
        end else if (low_power_request || (cur_q[0] == tgt[0] && cur_q[1] == tgt[1])) begin
            wake_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int ch = 0; ch < 2; ch++) begin
                cur_q[ch]   <= MUTE_LEVEL;
                timer_q[ch] <= '0;
                prev_q[ch]  <= '0;
            end
            pdn_prev_q <= 1'b0;
            wake_q     <= 1'b0;
        end else begin
            for (int ch = 0; ch < 2; ch++) begin
                cur_q[ch]   <= cur_d[ch];
                timer_q[ch] <= timer_d[ch];
                prev_q[ch]  <= prev_d[ch];
            end
            pdn_prev_q <= low_power_request;
            wake_q     <= wake_d;
        end
    end

    // Gain lookup: mantissa from the table, halvings and mute alongside
    logic [MANT_W-1:0] mant_q [2];
    logic [4:0]        seg_q [2], seg_d [2];
    logic              mute_lvl_q [2], mute_lvl_d [2];
    logic [5:0]        rom_addr [2];

    always_comb begin
        for (int ch = 0; ch < 2; ch++) begin
            rom_addr[ch]   = 6'(cur_q[ch] % LEVEL_W'(SEG_STEPS));
            seg_d[ch]      = 5'(cur_q[ch] / LEVEL_W'(SEG_STEPS));
            mute_lvl_d[ch] = (cur_q[ch] >= MUTE_LEVEL);
        end
    end

    gain_rom #(
        .DEPTH (SEG_STEPS),
        .WIDTH (MANT_W)
    ) u_gain_rom (
        .core_clk (core_clk),
        .rst      (rst),
        .addr_a   (rom_addr[0]),
        .addr_b   (rom_addr[1]),
        .data_a_q (mant_q[0]),
        .data_b_q (mant_q[1])
    );

    // Mixing matrix and output stage
    smp_t a_l, a_r, b_l, b_r, mix_a, mix_b, out_a_d, out_b_d;
    logic [1:0] sel_a, sel_b;
    logic ind_l_d, ind_r_d, low_power_d;

    always_comb begin
        a_l = atten(in_s[0], mant_q[0], seg_q[0], mute_lvl_q[0]);
        a_r = atten(in_s[1], mant_q[0], seg_q[0], mute_lvl_q[0]);
        b_l = atten(in_s[0], mant_q[1], seg_q[1], mute_lvl_q[1]);
        b_r = atten(in_s[1], mant_q[1], seg_q[1], mute_lvl_q[1]);
        sel_a = eff.mix[MIX_SEL_A_LSB +: 2];
        sel_b = eff.mix[MIX_SEL_B_LSB +: 2];
        mix_a = pick(sel_a, a_l, a_r);
        mix_b = pick(sel_b, b_l, b_r);
        if (eff.mix[MIX_CROSS_BIT] && sel_a == 2'b11) begin
            mix_a = (sel_b == 2'b10) ? avg2(b_l, a_r) : avg2(a_l, b_r);
        end
        if (eff.mix[MIX_CROSS_BIT] && sel_b == 2'b11) begin
            mix_b = (sel_a == 2'b00) ? avg2(b_l, a_r) : avg2(a_l, b_r);
        end
        out_a_d = eff.mode2[M2_INV_A_BIT] ? negate_sat(mix_a) : mix_a;
        out_b_d = eff.mode2[M2_INV_B_BIT] ? negate_sat(mix_b) : mix_b;
        ind_l_d = muted[0];
        ind_r_d = muted[1];
        if (eff.mode2[M2_IND_LINK_BIT]) begin
            ind_l_d = muted[0] && muted[1];
            ind_r_d = muted[0] && muted[1];
        end
        // Low power only once both levels have settled at mute
        low_power_d = low_power_request && cur_q[0] == MUTE_LEVEL && cur_q[1] == MUTE_LEVEL;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            seg_q                   <= '{default: '0};
            mute_lvl_q              <= '{default: 1'b1};
            analog_out_left_chan    <= '0;
            analog_out_right_chan   <= '0;
            out_valid               <= 1'b0;
            silence_indicator_left  <= 1'b0;
            silence_indicator_right <= 1'b0;
            low_power_state         <= 1'b0;
            master_clock_halve      <= 1'b0;
            rolloff_select          <= 1'b0;
            host_port_enable        <= 1'b0;
        end else begin
            seg_q      <= seg_d;
            mute_lvl_q <= mute_lvl_d;
            if (sample_valid) begin
                analog_out_left_chan  <= out_a_d;
                analog_out_right_chan <= out_b_d;
            end
            out_valid               <= sample_valid;
            silence_indicator_left  <= ind_l_d;
            silence_indicator_right <= ind_r_d;
            low_power_state         <= low_power_d;
            master_clock_halve      <= eff.mode2[M2_MCLK_BIT];
            rolloff_select          <= eff.mode3[M3_FILT_BIT];
            host_port_enable        <= applied_q.mode2[M2_HOST_PORT_ENABLE_BIT];
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    soft_step_a: assert property ($past(mode[0] == LC_SOFT) && cur_q[0] != $past(cur_q[0]) |->
        $past(sample_valid) && (cur_q[0] - $past(cur_q[0]) == 11'h001 || $past(cur_q[0]) - cur_q[0] == 11'h001))
        else $error("soft ramp moved more than one eighth dB or off a frame");
    immediate_a: assert property (mode[1] == LC_IMMEDIATE && cur_q[1] != tgt[1] |=> cur_q[1] == $past(tgt[1]))
        else $error("immediate mode did not jump to target");
    zc_wait_a: assert property ($past(mode[0] == LC_ZERO_CROSS) && cur_q[0] != $past(cur_q[0]) |->
        $past(zc[0] || tmo[0]))
        else $error("zero cross change without crossing or timeout");
    zc_bound_a: assert property (timer_q[0] <= ZC_TIMEOUT_LAST && timer_q[1] <= ZC_TIMEOUT_LAST)
        else $error("zero cross timeout overran");
    zc_soft_a: assert property ($past(mode[1] == LC_SOFT_ZERO) && cur_q[1] != $past(cur_q[1]) |->
        $past(zc[1] || tmo[1]))
        else $error("soft zero step off a crossing");
    link_vol_a: assert property (eff.mix[MIX_LINK_BIT] |-> tgt[0] == tgt[1])
        else $error("linked channels have different targets");
    ind_link_a: assert property ($past(eff.mode2[M2_IND_LINK_BIT]) |->
        silence_indicator_left == ($past(muted[0]) && $past(muted[1])) && silence_indicator_right == silence_indicator_left)
        else $error("linked indicators not the AND of both channels");
    mute_ind_a: assert property (!$past(eff.mode2[M2_IND_LINK_BIT]) |-> silence_indicator_left == $past(muted[0]))
        else $error("left indicator does not follow mute state");
    freeze_hold_a: assert property ($past(shadow_q.mode2[M2_FREEZE_BIT]) |-> $stable(applied_q))
        else $error("applied registers changed while frozen");
    spi_read_a: assert property (reg_rd && !two_wire_mode |=> !reg_rvalid && reg_rdata == 8'h00)
        else $error("read answered in four-wire mode");

    soft_ramp_c: cover property (mode[0] == LC_SOFT && sample_valid && cur_q[0] != tgt[0]);
    zc_timeout_c: cover property (tmo[1] && cur_q[1] != tgt[1]);
    freeze_release_c: cover property ($fell(shadow_q.mode2[M2_FREEZE_BIT]));
    low_power_c: cover property ($rose(low_power_state));

endmodule : volume_mix_ctrl

/* File: rtl/volume_mix_pkg.sv */
/*
 * Package for the volume, mixing and mode control block: register offsets,
 * field positions, reset values, level-change timing and the register carrier.
 * Assumes a single 20 MHz core clock and one sample_valid pulse per frame.
 */
package volume_mix_pkg;

    // Register offsets on the control port
    localparam logic [2:0] ADDR_MIX   = 3'h2;
    localparam logic [2:0] ADDR_VOL_A = 3'h3;
    localparam logic [2:0] ADDR_VOL_B = 3'h4;
    localparam logic [2:0] ADDR_MODE2 = 3'h5;
    localparam logic [2:0] ADDR_MODE3 = 3'h6;

    // Reset values
    localparam logic [7:0] RST_MIX   = 8'h49;
    localparam logic [7:0] RST_VOL   = 8'h00;
    localparam logic [7:0] RST_MODE2 = 8'h10;
    localparam logic [7:0] RST_MODE3 = 8'h00;

    // Writable bits; reserved bits read as zero
    localparam logic [7:0] MASK_MODE2 = 8'hFE;
    localparam logic [7:0] MASK_MODE3 = 8'h1C;

    // Field positions
    localparam int MIX_LINK_BIT = 7;
    localparam int MIX_MODE_LSB = 5;
    localparam int MIX_CROSS_BIT = 4;
    localparam int MIX_SEL_A_LSB = 2;
    localparam int MIX_SEL_B_LSB = 0;
    localparam int VOL_MUTE_BIT = 7;
    localparam int M2_INV_A_BIT = 7;
    localparam int M2_INV_B_BIT = 6;
    localparam int M2_HOST_PORT_ENABLE_BIT = 5;
    localparam int M2_PDN_BIT = 4;
    localparam int M2_IND_LINK_BIT = 3;
    localparam int M2_FREEZE_BIT = 2;
    localparam int M2_MCLK_BIT = 1;
    localparam int M3_FILT_BIT = 4;
    localparam int M3_RUP_BIT = 3;
    localparam int M3_RDN_BIT = 2;

    // Level in 1/8 dB steps of attenuation; the mute level lies past -127 dB
    localparam int             LEVEL_W    = 11;
    localparam logic [10:0]    MUTE_LEVEL = 11'h400;
    localparam int             STEP_SHIFT = 3;

    // Zero-cross timeout in sample periods (documented window 512..1024)
    localparam int             ZC_TIMEOUT_SAMPLES = 512;
    localparam int             TIMER_W            = 10;
    localparam logic [9:0]     ZC_TIMEOUT_LAST    = 10'(ZC_TIMEOUT_SAMPLES - 1);

    // Gain table: 48 eighth-dB steps per halving of amplitude
    localparam int             SEG_STEPS  = 48;
    localparam int             MANT_W     = 16;
    localparam int             MANT_FRAC  = 15;
    localparam logic [31:0]    MANT_UNITY = 32'h0000_8000;
    localparam logic [31:0]    MANT_STEP  = 32'h0000_FC58;

    localparam int             SAMPLE_W   = 24;

    typedef enum logic [1:0] {
        LC_IMMEDIATE,
        LC_ZERO_CROSS,
        LC_SOFT,
        LC_SOFT_ZERO
    } change_mode_e;

    typedef struct packed {
        logic [7:0] mix;
        logic [7:0] vol_a;
        logic [7:0] vol_b;
        logic [7:0] mode2;
        logic [7:0] mode3;
    } ctl_regs_s;

    localparam ctl_regs_s CTL_RESET = '{RST_MIX, RST_VOL, RST_VOL, RST_MODE2, RST_MODE3};
    // Stand-alone operation: defaults with the device running
    localparam ctl_regs_s CTL_STANDALONE = '{RST_MIX, RST_VOL, RST_VOL, 8'h00, RST_MODE3};

endpackage : volume_mix_pkg

/* File: verif/audio_src.sv */
/*
 * Audio source partner: one sample pair every fourth core clock.
 * Assumes the bench supplies the sample values and drives at falling edges.
 */
module audio_src
    import volume_mix_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic [SAMPLE_W-1:0] left_val,
    input  wire logic [SAMPLE_W-1:0] right_val,
    output logic                     sample_valid,
    output logic      [SAMPLE_W-1:0] sample_left,
    output logic      [SAMPLE_W-1:0] sample_right
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase_q = 2'h0;
    initial begin
        sample_valid = 1'b0;
        sample_left  = '0;
        sample_right = '0;
    end
    // Off-frame samples are inverted so a design latching at the wrong time is caught
    always @(negedge core_clk) begin
        phase_q      <= rst ? 2'h0 : phase_q + 2'h1;
        sample_valid <= !rst && phase_q == 2'h3;
        sample_left  <= (phase_q == 2'h3) ? left_val : ~left_val;
        sample_right <= (phase_q == 2'h3) ? right_val : ~right_val;
    end
endmodule : audio_src

/* File: verif/tb_top.sv */
/*
 * Register-driven test of volume, mixing, mute, freeze and mode outputs.
 * Assumes constant positive samples from the audio source partner.
 */
module tb_top
    import volume_mix_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [23:0] L_V = 24'h100000;
    localparam logic [23:0] R_V = 24'h080000;
    logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, two_wire_mode = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic reg_rvalid, sample_valid, out_valid, ind_l, ind_r, lp, mch, rof, hpe;
    logic [23:0] s_l, s_r, o_l, o_r;
    int n_fail = 0, compares = 0;
    always #25 core_clk = ~core_clk;
    audio_src src_u (.core_clk(core_clk), .rst(rst), .left_val(L_V), .right_val(R_V),
        .sample_valid(sample_valid), .sample_left(s_l), .sample_right(s_r));
    volume_mix_ctrl dut_u (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .two_wire_mode(two_wire_mode),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sample_valid(sample_valid),
        .sample_left(s_l), .sample_right(s_r), .analog_out_left_chan(o_l),
        .analog_out_right_chan(o_r), .out_valid(out_valid), .silence_indicator_left(ind_l),
        .silence_indicator_right(ind_r), .low_power_state(lp), .master_clock_halve(mch),
        .rolloff_select(rof), .host_port_enable(hpe));
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] exp, input logic ok);
        @(negedge core_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge core_clk);
        reg_rd = 1'b0;
        chk(reg_rvalid, ok);
        chk(reg_rdata, exp);
    endtask : rd
    // Frames are counted on the design's own output strobe; the watchdog bounds it
    task automatic frames(input int n);
        repeat (n) @(posedge out_valid);
        @(negedge core_clk);
    endtask : frames
    task automatic outs(input logic [23:0] l, input logic [23:0] r);
        chk(o_l, l);
        chk(o_r, r);
    endtask : outs
    task automatic final_report;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : final_report
    initial begin
        #500000;
        n_fail++;
        final_report();
    end
    initial begin
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        rd(3'h2, 8'h49, 1'b1);
        rd(3'h3, 8'h00, 1'b1);
        rd(3'h5, 8'h10, 1'b1);
        rd(3'h6, 8'h00, 1'b1);
        rd(3'h7, 8'h00, 1'b1);
        chk(hpe, 1'b0);
        wr(3'h6, 8'hF3);
        rd(3'h6, 8'h10, 1'b1);
        two_wire_mode = 1'b0;
        rd(3'h5, 8'h00, 1'b0);
        two_wire_mode = 1'b1;
        wr(3'h5, 8'h30);
        frames(4);
        chk(lp, 1'b1);
        chk({hpe, rof}, 2'h3);
        rd(3'h6, 8'h10, 1'b1);
        wr(3'h2, 8'h09);
        wr(3'h5, 8'h23);
        frames(4);
        rd(3'h5, 8'h22, 1'b1);
        chk({lp, mch}, 2'h1);
        outs(L_V, R_V);
        wr(3'h2, 8'h0F);
        frames(4);
        outs(24'h0C0000, 24'h0C0000);
        // Cross average with A muted leaves half of B's left sample
        wr(3'h3, 8'h80);
        wr(3'h2, 8'h13);
        frames(4);
        outs(24'h0, 24'h080000);
        wr(3'h3, 8'h00);
        wr(3'h2, 8'h00);
        frames(4);
        outs(24'h0, 24'h0);
        wr(3'h2, 8'h09);
        wr(3'h5, 8'hE0);
        frames(4);
        outs(24'(-L_V), 24'(-R_V));
        // The write that sets freeze is itself held, so the inversion stays
        wr(3'h5, 8'h24);
        wr(3'h3, 8'h80);
        frames(4);
        outs(24'(-L_V), 24'(-R_V));
        rd(3'h3, 8'h80, 1'b1);
        wr(3'h5, 8'h20);
        frames(4);
        outs(24'h0, R_V);
        chk({ind_l, ind_r}, 2'h2);
        wr(3'h5, 8'h28);
        frames(4);
        chk({ind_l, ind_r}, 2'h0);
        wr(3'h4, 8'h80);
        frames(4);
        chk({ind_l, ind_r}, 2'h3);
        wr(3'h5, 8'h20);
        wr(3'h3, 8'h00);
        wr(3'h2, 8'h89);
        frames(4);
        outs(L_V, R_V);
        wr(3'h4, 8'h00);
        wr(3'h2, 8'h29);
        frames(4);
        wr(3'h3, 8'h80);
        // Samples never cross zero, so only the forced timeout can apply the mute
        frames(500);
        outs(L_V, R_V);
        frames(530);
        outs(24'h0, R_V);
        final_report();
    end
endmodule : tb_top
